// ---- hw/maintenance_channel_filter.sv ----
module maintenance_channel_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Strap pins
  input wire logic auto_strap,
  input wire logic crc_filter_strap,
  // Register access message, shared by all ports
  input wire logic reg_wr,
  input wire logic [1:0] reg_port,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Per-port line timing and receive data
  input wire logic [mbit_pkg::PORTS-1:0] frame_end,
  input wire logic [mbit_pkg::PORTS-1:0] sframe_end,
  input wire logic [mbit_pkg::PORTS-1:0] crc_ok,
  input wire logic [mbit_pkg::PORTS-1:0] rx_sync,
  input wire logic [mbit_pkg::PORTS-1:0] deact_entry,
  input wire logic [mbit_pkg::PORTS-1:0] pwr_up,
  input wire logic [mbit_pkg::PORTS*3-1:0] rx_m123,
  input wire logic [mbit_pkg::PORTS*8-1:0] rx_m4,
  input wire logic [mbit_pkg::PORTS*4-1:0] rx_m56,
  // Return-message reference word
  input wire logic [mbit_pkg::PORTS*12-1:0] tx_ops_ref,
  // Overhead-bit commands
  input wire logic [mbit_pkg::PORTS-1:0] oh_cmd,
  input wire logic [mbit_pkg::PORTS*12-1:0] oh_cmd_bits,
  input wire logic [mbit_pkg::PORTS-1:0] sai_sel_cmd,
  input wire logic [mbit_pkg::PORTS-1:0] sai_sel_val,
  input wire logic [mbit_pkg::PORTS*8-1:0] fsm_m4,
  // Reports
  output logic [mbit_pkg::PORTS-1:0] ops_msg,
  output logic [mbit_pkg::PORTS*12-1:0] ops_word,
  output logic [mbit_pkg::PORTS-1:0] oh_msg,
  output logic [mbit_pkg::PORTS*12-1:0] oh_word,
  output logic [mbit_pkg::PORTS*8-1:0] fsm_rx_m4,
  output logic [mbit_pkg::PORTS*12-1:0] tx_oh
);
  import mbit_pkg::*;

  // ***********************************
  // Strap capture, once after reset
  // ***********************************
  logic strap_done_ff;
  logic auto_s1_ff, auto_s2_ff, crc_s1_ff, crc_s2_ff;
  always_ff @(posedge clk) begin
    auto_s1_ff <= auto_strap;
    auto_s2_ff <= auto_s1_ff;
    crc_s1_ff <= crc_filter_strap;
    crc_s2_ff <= crc_s1_ff;
    if (srst) begin
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
    end
  end
  wire logic strap_load = ~srst & ~strap_done_ff;
  wire logic [7:0] strap_val = {crc_s2_ff ? CRC_PRESET_ON : CRC_PRESET_OFF,
                                auto_s2_ff ? EOC_AUTO : EOC_TRANSP};

  logic [7:0] rd_mux [PORTS];
  assign reg_rdata = rd_mux[reg_port];

  // ***********************************
  // One filter instance per line port
  // ***********************************
  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      logic [7:0] filt_ff, act_ff, txm_ff, rxm_ff;
      wire logic wr_me = reg_wr && (reg_port == 2'(p));
      assign rd_mux[p] = (reg_sel == REG_TXMASK) ? txm_ff :
                         (reg_sel == REG_RXMASK) ? rxm_ff : filt_ff;
      always_ff @(posedge clk) begin
        if (srst) begin
          filt_ff <= 8'h00;
          txm_ff <= MASK_RESET;
          rxm_ff <= MASK_RESET;
          act_ff <= 8'h00;
        end else begin
          if (strap_load) begin
            filt_ff <= strap_val;
          end else if (wr_me && reg_sel == REG_FILT) begin
            filt_ff <= reg_wdata;
          end
          if (strap_load || deact_entry[p]) begin
            act_ff <= strap_load ? strap_val : filt_ff;
          end
          if (sai_sel_cmd[p]) begin
            txm_ff[SAI_BIT] <= sai_sel_val[p];
          end else if (wr_me && reg_sel == REG_TXMASK) begin
            txm_ff <= reg_wdata;
          end
          if (wr_me && reg_sel == REG_RXMASK) begin
            rxm_ff <= reg_wdata;
          end
        end
      end

      wire logic [2:0] eoc_mode = act_ff[EOC_LSB +: 3];
      wire logic m4_tll = act_ff[M4_LSB];
      wire logic m4_crc = act_ff[M4_LSB+1];
      wire logic sm_same = act_ff[SM_SEL_BIT];
      wire logic m56_chg = act_ff[M56_LSB];

      // Ops word assembly from four basic frames
      logic [OPS_W-1:0] asm_ff, ops_prev_ff, ops_cand_ff, ops_rep_ff;
      logic [1:0] fcnt_ff, ocnt_ff;
      logic [22:0] tmr_ff;
      logic word_ff;
      wire logic [OPS_W-1:0] asm_nxt = {asm_ff[8:0], rx_m123[p*3 +: 3]};
      wire logic word_done = frame_end[p] && fcnt_ff == 2'h3;
      wire logic same_prev = asm_nxt == ops_prev_ff;
      wire logic tll_hit = (asm_nxt == ops_cand_ff) && ocnt_ff >= 2'h1;
      wire logic echo_hit = asm_nxt == tx_ops_ref[p*12 +: 12];
      wire logic ops_tick = tmr_ff == 23'(OPS_PERIOD_CYC - 1);
      logic ops_fire;
      always_comb begin
        ops_fire = 1'b0;
        unique case (eoc_mode)
          EOC_AUTO: ops_fire = word_done && tll_hit &&
                               (echo_hit || asm_nxt != ops_rep_ff);
          EOC_ONCHG: ops_fire = word_done && !same_prev;
          EOC_TLL: ops_fire = word_done && tll_hit &&
                              asm_nxt != ops_rep_ff;
          default: ops_fire = 1'b0;
        endcase
      end
      wire logic transp = eoc_mode == EOC_TRANSP;
      always_ff @(posedge clk) begin
        if (srst) begin
          fcnt_ff <= 2'h0;
          ocnt_ff <= 2'h0;
          tmr_ff <= 23'h0;
          asm_ff <= 12'hFFF;
          ops_prev_ff <= 12'hFFF;
          ops_cand_ff <= 12'hFFF;
          ops_rep_ff <= 12'hFFF;
          word_ff <= 1'b0;
          ops_msg[p] <= 1'b0;
          ops_word[p*12 +: 12] <= 12'h000;
        end else begin
          ops_msg[p] <= 1'b0;
          tmr_ff <= ops_tick ? 23'h0 : tmr_ff + 23'h1;
          if (frame_end[p]) begin
            asm_ff <= asm_nxt;
            fcnt_ff <= sframe_end[p] ? 2'h0 : fcnt_ff + 2'h1;
          end
          if (word_done) begin
            word_ff <= 1'b1;
            ops_prev_ff <= asm_nxt;
            ops_cand_ff <= asm_nxt;
            ocnt_ff <= (asm_nxt == ops_cand_ff) ?
                       ((ocnt_ff == 2'h2) ? 2'h2 : ocnt_ff + 2'h1) : 2'h0;
          end
          if (rx_sync[p] && ((transp && ops_tick && word_ff) ||
                             (!transp && ops_fire))) begin
            ops_msg[p] <= 1'b1;
            ops_word[p*12 +: 12] <= transp ? ops_prev_ff : asm_nxt;
            ops_rep_ff <= transp ? ops_prev_ff : asm_nxt;
          end
        end
      end

      // Overhead bits: M4 (8) then M5/M6 spares (4)
      logic [7:0] m4_val_ff, m4_p1_ff, m4_p2_ff, m4_sm_ff;
      logic [7:0] m4_pend_ff;
      logic [3:0] m56_val_ff, m56_p1_ff;
      logic [7:0] m4_sf_ff;
      logic [3:0] m56_sf_ff;
      logic crc_pend_ff;
      wire logic [7:0] m4_in = rx_m4[p*8 +: 8];
      wire logic [3:0] m56_in = rx_m56[p*4 +: 4];
      logic [7:0] m4_ok, sm_ok;
      for (genvar b = 0; b < 8; b++) begin : g_bit
        wire logic tll3 = (m4_in[b] == m4_p1_ff[b]) &&
                          (m4_p1_ff[b] == m4_p2_ff[b]);
        assign m4_ok[b] = m4_tll ? tll3 : 1'b1;
        assign sm_ok[b] = sm_same ? m4_ok[b] : tll3;
      end
      wire logic m56_ok = m56_chg ? 1'b1 : m4_tll ? (m56_in == m56_p1_ff)
                          : 1'b1;
      wire logic [7:0] m4_nv = (m4_val_ff & ~m4_ok) | (m4_in & m4_ok);
      wire logic [3:0] m56_nv = m56_ok ? m56_in : m56_val_ff;
      wire logic [7:0] sm_nv = (m4_sm_ff & ~sm_ok) | (m4_in & sm_ok);
      wire logic m4_rep = |((m4_nv ^ m4_sf_ff) & rxm_ff);
      wire logic m56_rep = m56_nv != m56_sf_ff;
      always_ff @(posedge clk) begin
        if (srst || pwr_up[p]) begin
          m4_val_ff <= 8'hFF;
          m4_p1_ff <= 8'hFF;
          m4_p2_ff <= 8'hFF;
          m4_sm_ff <= 8'hFF;
          m4_pend_ff <= 8'hFF;
          m56_val_ff <= 4'hF;
          m56_p1_ff <= 4'hF;
          m4_sf_ff <= 8'hFF;
          m56_sf_ff <= 4'hF;
          crc_pend_ff <= 1'b0;
          oh_msg[p] <= 1'b0;
          oh_word[p*12 +: 12] <= OH_ONES;
        end else begin
          oh_msg[p] <= 1'b0;
          if (frame_end[p]) begin
            // State machine sees approved bits at basic-frame end
            if (!(sm_same && m4_crc)) begin
              m4_sm_ff <= sm_nv;
            end
          end
          if (sframe_end[p]) begin
            m4_p2_ff <= m4_p1_ff;
            m4_p1_ff <= m4_in;
            m56_p1_ff <= m56_in;
            if (m4_crc) begin
              // Hold one superframe until its CRC arrives
              m4_pend_ff <= m4_nv;
              m56_val_ff <= m56_nv;
              crc_pend_ff <= 1'b1;
              if (crc_pend_ff && crc_ok[p]) begin
                m4_val_ff <= m4_pend_ff;
                if (sm_same) begin
                  m4_sm_ff <= m4_pend_ff;
                end
                if (rx_sync[p] && ((|((m4_pend_ff ^ m4_sf_ff) & rxm_ff))
                                   || m56_val_ff != m56_sf_ff)) begin
                  oh_msg[p] <= 1'b1;
                  oh_word[p*12 +: 12] <= {m4_pend_ff, m56_val_ff};
                  m4_sf_ff <= m4_pend_ff;
                  m56_sf_ff <= m56_val_ff;
                end
              end
            end else begin
              m4_val_ff <= m4_nv;
              m56_val_ff <= m56_nv;
              if (rx_sync[p] && (m4_rep || m56_rep)) begin
                oh_msg[p] <= 1'b1;
                oh_word[p*12 +: 12] <= {m4_nv, m56_nv};
                m4_sf_ff <= m4_nv;
                m56_sf_ff <= m56_nv;
              end
            end
          end
        end
      end
      assign fsm_rx_m4[p*8 +: 8] = rxm_ff[SAI_BIT] ? m4_sm_ff :
             (m4_sm_ff | (8'h01 << SAI_BIT));

      // Transmit side: command latch applied per superframe
      logic [11:0] cmd_ff, tx_ff;
      logic [7:0] m4_last_ff;
      logic [1:0] rep_ff;
      wire logic [7:0] tx_sel = (txm_ff & fsm_m4[p*8 +: 8]) |
                                (~txm_ff & cmd_ff[11:4]);
      always_ff @(posedge clk) begin
        if (srst || pwr_up[p]) begin
          cmd_ff <= OH_ONES;
          tx_ff <= OH_ONES;
          m4_last_ff <= 8'hFF;
          rep_ff <= 2'h0;
        end else begin
          if (oh_cmd[p]) begin
            cmd_ff <= oh_cmd_bits[p*12 +: 12];
          end
          if (sframe_end[p]) begin
            // Hold a new M4 value for three superframes
            if (rep_ff != 2'h0) begin
              rep_ff <= rep_ff - 2'h1;
              tx_ff[3:0] <= cmd_ff[3:0];
            end else begin
              tx_ff <= {tx_sel, cmd_ff[3:0]};
              if (tx_sel != m4_last_ff) begin
                rep_ff <= REPEAT_CNT - 2'h1;
                m4_last_ff <= tx_sel;
              end
            end
          end
        end
      end
      assign tx_oh[p*12 +: 12] = tx_ff;

      chk_ops_sync: assert property (@(posedge clk) disable iff (srst)
        ops_msg[p] |-> $past(rx_sync[p]))
        else $error("ops message without sync");
      chk_oh_sync: assert property (@(posedge clk) disable iff (srst)
        oh_msg[p] |-> $past(rx_sync[p]) && $past(sframe_end[p]))
        else $error("overhead message off superframe");
      chk_tx_hold: assert property (@(posedge clk) disable iff (srst)
        (sframe_end[p] && rep_ff == 2'h0 && tx_sel != m4_last_ff
         && !pwr_up[p]) |=> rep_ff == 2'h2)
        else $error("repeat count not loaded");

      // A fresh ops word in on-change mode must be reported next cycle
      sequence s_new_word;
        word_done && !same_prev;
      endsequence
      chk_onchg_report: assert property (@(posedge clk) disable iff (srst)
        (rx_sync[p] && eoc_mode == EOC_ONCHG) ##0 s_new_word |=> ops_msg[p])
        else $error("changed ops word not reported");
      chk_pwr_ones: assert property (@(posedge clk) disable iff (srst)
        pwr_up[p] |=> tx_oh[p*12 +: 12] == OH_ONES &&
                      oh_word[p*12 +: 12] == OH_ONES)
        else $error("overhead bits not ones after power-up");
      chk_tx_steady: assert property (@(posedge clk) disable iff (srst)
        (sframe_end[p] && rep_ff != 2'h0 && !pwr_up[p]) |=>
        tx_oh[p*12+4 +: 8] == $past(tx_oh[p*12+4 +: 8]))
        else $error("transmitted M4 changed during repeat");
    end
  endgenerate
endmodule

// ---- hw/mbit_pkg.sv ----
// Summary of operation
// - Automode reports ops word after three-match check
// - Transparent mode forwards ops word every 6 ms
// - On-change mode reports only differing ops words
// - Three-match mode reports after three identical words
// - New M4 value repeats three transmitted superframes
// - Leaving power-down sets all overhead bits one
// - Per-bit M4 validation by filter field mode
// - Bit 5 picks state-machine M4 validation mode
// - M5/M6 use two-match when M4 is three-match, or on-change
// - M5/M6 reports CRC covered whenever M4 is
// - CRC-covered reports delayed one superframe
// - Auto strap presets ops-word filter field
// - CRC strap presets upper five config bits
// - Straps once; config applied on deactivated entry
// - State-machine M4 passes at basic frame end
// - Bit 5 with CRC informs next superframe end
// - Transmit mask zero takes commanded M4 value
// - Transmit mask bit 6 selects SUBSCRIBER_ACTIVITY_INDICATOR source
// - Receive mask gates reports; bit 6 forces SUBSCRIBER_ACTIVITY_INDICATOR
// - Commanded M4 loads next superframe; spares overwrite
// - Overhead message carries latest validated bits
// - Messages only while receiver synchronised
// - Ops word from four frames; overhead per superframe
package mbit_pkg;
  localparam int unsigned PORTS = 4;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned OPS_PERIOD_MS = 6;
  localparam int unsigned OPS_PERIOD_CYC = CLK_HZ / 1000 * OPS_PERIOD_MS;
  localparam int unsigned OPS_W = 12;
  localparam int unsigned OH_W = 12;
  // Configuration field positions
  localparam int unsigned EOC_LSB = 0;
  localparam int unsigned M4_LSB = 3;
  localparam int unsigned SM_SEL_BIT = 5;
  localparam int unsigned M56_LSB = 6;
  localparam logic [2:0] EOC_AUTO = 3'h4;
  localparam logic [2:0] EOC_TRANSP = 3'h1;
  localparam logic [2:0] EOC_ONCHG = 3'h2;
  localparam logic [2:0] EOC_TLL = 3'h3;
  localparam logic [4:0] CRC_PRESET_ON = 5'h06;
  localparam logic [4:0] CRC_PRESET_OFF = 5'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam logic [OH_W-1:0] OH_ONES = 12'hFFF;
  localparam int unsigned SAI_BIT = 6;
  localparam logic [1:0] REPEAT_CNT = 2'h3;
  // Register-access message selector
  localparam logic [1:0] REG_FILT = 2'h0;
  localparam logic [1:0] REG_TXMASK = 2'h1;
  localparam logic [1:0] REG_RXMASK = 2'h2;
endpackage

// ---- dv/line_card_model.sv ----
module line_card_model (
  // Clock
  input wire logic clk,
  // Reports from the device
  input wire logic [7:0] reg_rdata,
  input wire logic [mbit_pkg::PORTS-1:0] ops_msg,
  input wire logic [mbit_pkg::PORTS*12-1:0] ops_word,
  input wire logic [mbit_pkg::PORTS-1:0] oh_msg,
  input wire logic [mbit_pkg::PORTS*12-1:0] oh_word,
  // Requests towards the device
  output logic reg_wr,
  output logic [1:0] reg_port,
  output logic [1:0] reg_sel,
  output logic [7:0] reg_wdata,
  output logic [mbit_pkg::PORTS-1:0] oh_cmd,
  output logic [mbit_pkg::PORTS*12-1:0] oh_cmd_bits,
  output logic [mbit_pkg::PORTS-1:0] sai_sel_cmd,
  output logic [mbit_pkg::PORTS-1:0] sai_sel_val
);
  timeunit 1ns;
  timeprecision 1ns;
  import mbit_pkg::*;
  int ops_cnt[PORTS];
  int oh_cnt[PORTS];
  logic [11:0] ops_last[PORTS];
  logic [11:0] oh_last[PORTS];
  logic local_loop = 1'b0;
  initial begin
    {reg_wr, reg_port, reg_sel, reg_wdata} = '0;
    {oh_cmd, oh_cmd_bits, sai_sel_cmd, sai_sel_val} = '0;
    foreach (ops_cnt[i]) begin
      ops_cnt[i] = 0;
      oh_cnt[i] = 0;
    end
  end
  // **********************************************************
  // Message collection per port
  // **********************************************************
  always @(posedge clk) begin
    for (int i = 0; i < PORTS; i++) begin
      if (ops_msg[i] === 1'b1) begin
        ops_cnt[i]++;
        ops_last[i] = ops_word[i*12+:12];
      end
      if (oh_msg[i] === 1'b1) begin
        oh_cnt[i]++;
        oh_last[i] = oh_word[i*12+:12];
      end
    end
  end
  // **********************************************************
  // Requests, held for one taking edge
  // **********************************************************
  task automatic write_reg(input logic [1:0] p, s, input logic [7:0] d);
    // Transmit-mask programming is withheld while the loop test runs
    if (local_loop && s == REG_TXMASK) return;
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_port <= p;
    reg_sel <= s;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic read_reg(input logic [1:0] p, s, output logic [7:0] d);
    @(posedge clk);
    reg_port <= p;
    reg_sel <= s;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic send_cmd(input int p, input logic [11:0] b);
    @(posedge clk);
    oh_cmd[p] <= 1'b1;
    oh_cmd_bits[p*12+:12] <= b;
    @(posedge clk);
    oh_cmd <= '0;
  endtask
  task automatic sai_select(input int p, input logic v);
    if (local_loop) return;
    @(posedge clk);
    sai_sel_cmd[p] <= 1'b1;
    sai_sel_val[p] <= v;
    @(posedge clk);
    sai_sel_cmd <= '0;
  endtask
endmodule

// ---- dv/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mbit_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic auto_strap = 1'b1;
  logic crc_filter_strap = 1'b0;
  logic [PORTS-1:0] frame_end = '0, sframe_end = '0, crc_ok = '0;
  logic [PORTS-1:0] rx_sync = '0, deact_entry = '0, pwr_up = '0;
  logic [PORTS*3-1:0] rx_m123 = '0;
  logic [PORTS*8-1:0] rx_m4 = '1, fsm_m4 = '0;
  logic [PORTS*4-1:0] rx_m56 = '1;
  logic [PORTS*12-1:0] tx_ops_ref = '0;
  wire logic reg_wr;
  wire logic [1:0] reg_port, reg_sel;
  wire logic [7:0] reg_wdata, reg_rdata;
  wire logic [PORTS-1:0] oh_cmd, sai_sel_cmd, sai_sel_val, ops_msg, oh_msg;
  wire logic [PORTS*12-1:0] oh_cmd_bits, ops_word, oh_word, tx_oh;
  wire logic [PORTS*8-1:0] fsm_rx_m4;
  int err_total = 0;
  int n_checks = 0;
  logic [31:0] rnd = 32'h7427C362;
  logic [11:0] w, v;
  logic [7:0] d;
  always #50 clk = ~clk;
  maintenance_channel_filter dut (.clk(clk), .srst(srst),
    .auto_strap(auto_strap), .crc_filter_strap(crc_filter_strap),
    .reg_wr(reg_wr), .reg_port(reg_port), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_end(frame_end),
    .sframe_end(sframe_end), .crc_ok(crc_ok), .rx_sync(rx_sync),
    .deact_entry(deact_entry), .pwr_up(pwr_up), .rx_m123(rx_m123),
    .rx_m4(rx_m4), .rx_m56(rx_m56), .tx_ops_ref(tx_ops_ref),
    .oh_cmd(oh_cmd), .oh_cmd_bits(oh_cmd_bits), .sai_sel_cmd(sai_sel_cmd),
    .sai_sel_val(sai_sel_val), .fsm_m4(fsm_m4), .ops_msg(ops_msg),
    .ops_word(ops_word), .oh_msg(oh_msg), .oh_word(oh_word),
    .fsm_rx_m4(fsm_rx_m4), .tx_oh(tx_oh));
  line_card_model lcm (.clk(clk), .reg_rdata(reg_rdata), .ops_msg(ops_msg),
    .ops_word(ops_word), .oh_msg(oh_msg), .oh_word(oh_word),
    .reg_wr(reg_wr), .reg_port(reg_port), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .oh_cmd(oh_cmd), .oh_cmd_bits(oh_cmd_bits),
    .sai_sel_cmd(sai_sel_cmd), .sai_sel_val(sai_sel_val));
  // **********************************************************
  // Bench helpers
  // **********************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] strap_cfg(input logic a, c);
    return {c ? CRC_PRESET_ON : CRC_PRESET_OFF, a ? EOC_AUTO : EOC_TRANSP};
  endfunction
  task automatic cmp(input logic [11:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpn(input int got, exp);
    cmp(12'(got), 12'(exp));
  endtask
  task automatic frame(input int p, input logic [2:0] m, input logic last,
      input logic [7:0] a, input logic [3:0] b, input logic c);
    @(posedge clk);
    frame_end[p] <= 1'b1;
    sframe_end[p] <= last;
    rx_m123[p*3+:3] <= m;
    rx_m4[p*8+:8] <= a;
    rx_m56[p*4+:4] <= b;
    crc_ok[p] <= c;
    @(posedge clk);
    frame_end <= '0;
    sframe_end <= '0;
    @(posedge clk);
  endtask
  // One superframe carrying two ops words; message counts are compared
  task automatic run(input int p, input logic [11:0] w0, w1,
      input logic [7:0] a, input logic [3:0] b, input logic c, input int eo,
      input int eh);
    int o0, h0;
    o0 = lcm.ops_cnt[p];
    h0 = lcm.oh_cnt[p];
    for (int i = 0; i < 8; i++) begin
      frame(p, 3'((i < 4 ? w0 : w1) >> (3 * (3 - i % 4))), i == 7, a, b, c);
    end
    repeat (3) @(posedge clk);
    cmpn(lcm.ops_cnt[p] - o0, eo);
    cmpn(lcm.oh_cnt[p] - h0, eh);
  endtask
  task automatic apply(input int p, input logic [7:0] cfg);
    lcm.write_reg(2'(p), REG_FILT, cfg);
    @(posedge clk);
    deact_entry[p] <= 1'b1;
    @(posedge clk);
    deact_entry <= '0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    give_verdict();
  end
  // **********************************************************
  // Scenarios
  // **********************************************************
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    auto_strap <= 1'b0;
    cmp(oh_word[11:0], OH_ONES);
    cmp(ops_word[11:0], 12'h000);
    lcm.read_reg(2'h0, REG_FILT, d);
    cmp({4'h0, d}, {4'h0, strap_cfg(1'b1, 1'b0)});
    $display("test reset done");
    rnd = lfsr(rnd);
    w = rnd[11:0] | 12'h001;
    apply(1, {CRC_PRESET_OFF, EOC_ONCHG});
    rx_sync[1] <= 1'b1;
    run(1, w, w, 8'hFF, 4'hF, 1'b1, 1, 0);
    cmp(lcm.ops_last[1], w);
    run(1, w, w, 8'hFF, 4'hF, 1'b1, 0, 0);
    run(1, w ^ 12'h800, w, 8'hFF, 4'hF, 1'b1, 2, 0);
    $display("test on_change done");
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      v = rnd[11:0] ^ w ^ 12'h400;
      tx_ops_ref[1*12+:12] <= ~v;
      apply(1, {CRC_PRESET_OFF, k == 0 ? EOC_TLL : EOC_AUTO});
      run(1, v, v, 8'hFF, 4'hF, 1'b1, 0, 0);
      run(1, v, w, 8'hFF, 4'hF, 1'b1, 1, 0);
      cmp(lcm.ops_last[1], v);
      w = v;
    end
    // Echo of the last sent word is reported even when unchanged
    tx_ops_ref[1*12+:12] <= w;
    run(1, w, w, 8'hFF, 4'hF, 1'b1, 0, 0);
    run(1, w, ~w, 8'hFF, 4'hF, 1'b1, 1, 0);
    cmp(lcm.ops_last[1], w);
    $display("test three_match done");
    rx_sync[1] <= 1'b0;
    run(1, ~w, ~w, 8'h00, 4'h0, 1'b1, 0, 0);
    run(1, ~w, ~w, 8'h00, 4'h0, 1'b1, 0, 0);
    $display("test unsynced done");
    rnd = lfsr(rnd);
    rx_sync[2] <= 1'b1;
    run(2, 12'h0, 12'h0, rnd[7:0] & 8'hFE, rnd[11:8] & 4'hE, 1'b1, 0, 1);
    cmp(lcm.oh_last[2], {rnd[7:0] & 8'hFE, rnd[11:8] & 4'hE});
    run(2, 12'h0, 12'h0, rnd[7:0] & 8'hFE, rnd[11:8] & 4'hE, 1'b1, 2, 0);
    apply(2, {CRC_PRESET_ON, EOC_ONCHG});
    run(2, 12'h0, 12'h0, 8'h5A, rnd[11:8] & 4'hE, 1'b1, 0, 0);
    run(2, 12'h0, 12'h0, 8'h5A, rnd[11:8] & 4'hE, 1'b1, 0, 1);
    cmp(lcm.oh_last[2], {8'h5A, rnd[11:8] & 4'hE});
    run(2, 12'h0, 12'h0, 8'hA5, rnd[11:8] & 4'hE, 1'b1, 0, 0);
    run(2, 12'h0, 12'h0, 8'hA5, rnd[11:8] & 4'hE, 1'b0, 0, 0);
    $display("test overhead done");
    rnd = lfsr(rnd);
    fsm_m4 <= {PORTS{rnd[7:0] & 8'h7F}};
    run(3, 12'h0, 12'h0, 8'hFF, 4'hF, 1'b1, 0, 0);
    cmp({4'h0, tx_oh[36+4+:8]}, {4'h0, rnd[7:0] & 8'h7F});
    lcm.send_cmd(3, rnd[19:8]);
    lcm.write_reg(2'h3, REG_TXMASK, 8'h00);
    run(3, 12'h0, 12'h0, 8'hFF, 4'hF, 1'b1, 0, 0);
    cmp(tx_oh[36+:12], {rnd[7:0] & 8'h7F, rnd[11:8]});
    repeat (2) run(3, 12'h0, 12'h0, 8'hFF, 4'hF, 1'b1, 0, 0);
    cmp(tx_oh[36+:12], rnd[19:8]);
    lcm.sai_select(3, 1'b1);
    lcm.read_reg(2'h3, REG_TXMASK, d);
    cmp({4'h0, d}, 12'h040);
    lcm.write_reg(2'h3, REG_RXMASK, 8'hBF);
    repeat (2) @(posedge clk);
    cmp({11'h0, fsm_rx_m4[3*8+SAI_BIT]}, 12'h001);
    @(posedge clk);
    pwr_up[3] <= 1'b1;
    @(posedge clk);
    pwr_up <= '0;
    repeat (2) @(posedge clk);
    cmp(tx_oh[36+:12], OH_ONES);
    cmpn(lcm.ops_cnt[0] + lcm.oh_cnt[0] + lcm.ops_cnt[3], 0);
    $display("test transmit done");
    apply(0, {CRC_PRESET_OFF, EOC_TRANSP});
    rx_sync[0] <= 1'b1;
    run(0, w, w, 8'hFF, 4'hF, 1'b1, 0, 0);
    repeat (OPS_PERIOD_CYC) @(posedge clk);
    cmpn(lcm.ops_cnt[0], 1);
    cmp(lcm.ops_last[0], w);
    $display("test transparent done");
    give_verdict();
  end
endmodule
